// ### hdl/artc_pkg.sv
// shared constants and types for the rate, debounce and tap configuration block
package artc_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_X_RESULT   = 8'h00;
   localparam logic [7:0] ADDR_Y_RESULT   = 8'h01;
   localparam logic [7:0] ADDR_Z_RESULT   = 8'h02;
   localparam logic [7:0] ADDR_TILT       = 8'h03;
   localparam logic [7:0] ADDR_MODE       = 8'h07;
   localparam logic [7:0] ADDR_RATE       = 8'h08;
   localparam logic [7:0] ADDR_TAP_CFG    = 8'h09;
   localparam logic [7:0] ADDR_ENG_STATUS = 8'h0b;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int MODE_ACTIVE_BIT  = 0;
   localparam int RATE_SEL_LSB     = 0;
   localparam int DEBOUNCE_LSB     = 5;
   localparam int TAP_THR_LSB      = 0;
   localparam int X_EXCLUDE_BIT    = 5;
   localparam int Y_EXCLUDE_BIT    = 6;
   localparam int Z_EXCLUDE_BIT    = 7;
   localparam logic [7:0] MODE_RESET    = 8'h00;
   localparam logic [7:0] RATE_RESET    = 8'h00;
   localparam logic [7:0] TAP_CFG_RESET = 8'h00;

   // ------------------------------------------------------------
   // rate codes
   // ------------------------------------------------------------
   localparam logic [2:0] RATE_100_SPS    = 3'h2;
   localparam logic [2:0] RATE_50_SPS     = 3'h3;
   localparam logic [2:0] RATE_25_SPS     = 3'h4;
   localparam logic [2:0] RATE_12P5_SPS   = 3'h5;
   localparam logic [2:0] RATE_6P25_SPS   = 3'h6;
   localparam logic [2:0] RATE_3P125_SPS  = 3'h7;

   // ------------------------------------------------------------
   // timing: tap sampling at 200 samples per second
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 5;
   localparam int TAP_PERIOD_NS    = 5000000;
   localparam int TAP_PERIOD_CYC   = TAP_PERIOD_NS / CLK_PERIOD_NS;
   localparam int RATE_DIV_W       = 6;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] x;
      logic [7:0] y;
      logic [7:0] z;
   } artc_axes_type;

   typedef struct packed {
      logic       wr_en;
      logic [7:0] addr;
      logic [7:0] data;
   } artc_wr_type;

endpackage

// ### hdl/artc_i2c_slave.sv
// i2c register port: byte pointer, auto-increment writes and reads
module artc_i2c_slave
   import artc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary value
)(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output      logic        sda_out,
   output      logic        sda_oe_n,
   output      logic [7:0]  rd_addr,
   input  wire logic [7:0]  rd_data,
   output      artc_wr_type wr
);

   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_ADDR  = 9'h002,
      ST_ACK_A = 9'h004,
      ST_REG   = 9'h008,
      ST_ACK_R = 9'h010,
      ST_WDATA = 9'h020,
      ST_ACK_W = 9'h040,
      ST_RDATA = 9'h080,
      ST_ACK_D = 9'h100
   } artc_i2c_state_type;

   artc_i2c_state_type state_r;
   logic [1:0] scl_sync_r;
   logic [1:0] sda_sync_r;
   logic       scl_prev_r;
   logic       sda_prev_r;
   logic [7:0] shift_r;
   logic [3:0] bits_r;
   logic [7:0] ptr_r;
   logic       read_r;
   logic       ack_ok_r;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_seen;
   logic       stop_seen;

   // ------------------------------------------------------------
   // pin synchronisers and edge detection
   // ------------------------------------------------------------
   // pins are asynchronous: two flops before any decision
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         scl_sync_r <= 2'h3;
         sda_sync_r <= 2'h3;
         scl_prev_r <= 1'b1;
         sda_prev_r <= 1'b1;
      end else begin
         scl_sync_r <= {scl_sync_r[0], scl_in};
         sda_sync_r <= {sda_sync_r[0], sda_in};
         scl_prev_r <= scl_sync_r[1];
         sda_prev_r <= sda_sync_r[1];
      end
   end

   assign scl_rise   = scl_sync_r[1] & ~scl_prev_r;
   assign scl_fall   = ~scl_sync_r[1] & scl_prev_r;
   assign start_seen = scl_sync_r[1] & scl_prev_r & sda_prev_r
                       & ~sda_sync_r[1];
   assign stop_seen  = scl_sync_r[1] & scl_prev_r & ~sda_prev_r
                       & sda_sync_r[1];
   assign sda_out    = 1'b0;     // open drain: only ever pulls low
   assign rd_addr    = ptr_r;

   // ------------------------------------------------------------
   // byte engine
   // ------------------------------------------------------------
   // sda only changes on scl low, so the master never sees a false stop
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r  <= ST_IDLE;
         shift_r  <= 8'h00;
         bits_r   <= 4'h0;
         ptr_r    <= 8'h00;
         read_r   <= 1'b0;
         ack_ok_r <= 1'b0;
         sda_oe_n <= 1'b1;
         wr       <= '0;
      end else begin
         wr.wr_en <= 1'b0;
         if (start_seen) begin
            state_r  <= ST_ADDR;
            bits_r   <= 4'h0;
            sda_oe_n <= 1'b1;
         end else if (stop_seen) begin
            state_r  <= ST_IDLE;
            sda_oe_n <= 1'b1;
         end else if (scl_rise) begin
            if (state_r == ST_ACK_D) begin
               ack_ok_r <= ~sda_sync_r[1];
            end else if (state_r != ST_IDLE) begin
               shift_r <= {shift_r[6:0], sda_sync_r[1]};
               bits_r  <= bits_r + 4'h1;
            end
         end else if (scl_fall) begin
            unique case (state_r)
               ST_IDLE: begin
               end
               ST_ADDR: if (bits_r == 4'h8) begin
                  if (shift_r[7:1] == DEV_ADDR) begin
                     read_r   <= shift_r[0];
                     sda_oe_n <= 1'b0;
                     state_r  <= ST_ACK_A;
                  end else begin
                     state_r  <= ST_IDLE;
                  end
               end
               ST_ACK_A: begin
                  bits_r <= 4'h0;
                  if (read_r) begin
                     shift_r  <= rd_data;
                     sda_oe_n <= rd_data[7];
                     state_r  <= ST_RDATA;
                  end else begin
                     sda_oe_n <= 1'b1;
                     state_r  <= ST_REG;
                  end
               end
               ST_REG: if (bits_r == 4'h8) begin
                  ptr_r    <= shift_r;
                  sda_oe_n <= 1'b0;
                  state_r  <= ST_ACK_R;
               end
               ST_ACK_R, ST_ACK_W: begin
                  if (state_r == ST_ACK_W) begin
                     ptr_r <= ptr_r + 8'h01;
                  end
                  sda_oe_n <= 1'b1;
                  bits_r   <= 4'h0;
                  state_r  <= ST_WDATA;
               end
               ST_WDATA: if (bits_r == 4'h8) begin
                  wr       <= '{wr_en: 1'b1, addr: ptr_r, data: shift_r};
                  sda_oe_n <= 1'b0;
                  state_r  <= ST_ACK_W;
               end
               ST_RDATA: begin
                  if (bits_r == 4'h8) begin
                     sda_oe_n <= 1'b1;
                     ptr_r    <= ptr_r + 8'h01;
                     state_r  <= ST_ACK_D;
                  end else begin
                     sda_oe_n <= shift_r[7];  // shifted on the rise
                  end
               end
               ST_ACK_D: begin
                  bits_r <= 4'h0;
                  if (ack_ok_r) begin
                     shift_r  <= rd_data;
                     sda_oe_n <= rd_data[7];
                     state_r  <= ST_RDATA;
                  end else begin
                     state_r  <= ST_IDLE;
                  end
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end

endmodule

// ### hdl/artc_motion_cfg.sv
// motion engine configuration: output rate, tilt debounce, tap compare
//
// Functional notes
// - code 011 updates results at 50 sps
// - code 100 updates results at 25 sps
// - code 101 updates results at 12.5 sps
// - code 110 updates results at 6.25 sps
// - code 111 updates results at 3.125 sps
// - tap sampling always 200 sps when active
// - tap compares abs consecutive difference to threshold
// - free-fall disabled for codes 010 to 111
// - each rate sample written to axis results
// - debounce 000 updates tilt every reading
// - debounce code n needs n+1 matches
// - tap exclude bits drop z, y, x
// - threshold code n (code 0 taken as 1) means n times 62.5 mg
// - active entry starts at programmed rate
module artc_motion_cfg
   import artc_pkg::*;
#(
   parameter int         TAP_TICK_CYC  = TAP_PERIOD_CYC,
   parameter int         TAP_STEP_LSB  = 1,
   parameter logic [6:0] DEV_ADDR      = 7'h2a  // arbitrary value
)(
   input  wire logic          clock,
   input  wire logic          reset,
   input  wire logic          scl_in,
   input  wire logic          sda_in,
   output      logic          sda_out,
   output      logic          sda_oe_n,
   input  wire artc_axes_type axis_sample,
   input  wire logic [2:0]    orient_sample,
   output      artc_axes_type axis_result,
   output      logic [2:0]    orientation,
   output      logic          active,
   output      logic          tap_tick,
   output      logic          rate_tick,
   output      logic [2:0]    tap_hit,
   output      logic          freefall_enable
);

   initial begin
      if (TAP_TICK_CYC < 2 || TAP_STEP_LSB < 1 || TAP_STEP_LSB > 8) begin
         $error("artc_motion_cfg: unsupported parameter value");
      end
   end

   localparam int TICK_W = $clog2(TAP_TICK_CYC);

   logic [7:0]            mode_r;
   logic [7:0]            rate_cfg_r;
   logic [7:0]            tap_cfg_r;
   logic                  active_d_r;
   logic                  entry;
   logic [TICK_W-1:0]     tick_cnt_r;
   logic [RATE_DIV_W-1:0] div_cnt_r;
   logic [RATE_DIV_W-1:0] div_mask;
   artc_axes_type         prev_r;
   logic                  prev_ok_r;
   logic [2:0]            cand_r;
   logic [2:0]            match_r;
   logic [2:0]            last_hit_r;
   logic [7:0]            rd_addr;
   logic [7:0]            rd_data;
   artc_wr_type           wr;
   logic [2:0]            rate_sel;
   logic [2:0]            debounce;
   logic [2:0]            exclude;
   logic [7:0]            thr_lsb;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // absolute difference of two signed axis readings, 9 bits wide
   function automatic logic [8:0] abs_diff(input logic [7:0] a,
                                           input logic [7:0] b);
      logic signed [8:0] d;
      d = $signed({a[7], a}) - $signed({b[7], b});
      abs_diff = d[8] ? 9'(-d) : 9'(d);
   endfunction

   // number of 200 sps ticks per output sample, less one
   function automatic logic [RATE_DIV_W-1:0] rate_mask(
      input logic [2:0] code);
      rate_mask = '0;
      if (code >= RATE_100_SPS) begin
         rate_mask = RATE_DIV_W'((7'h1 << (code - 3'h1)) - 7'h1);
      end
   endfunction

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   artc_i2c_slave #(
      .DEV_ADDR (DEV_ADDR)
   ) u_port (
      .clock    (clock),
      .reset    (reset),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .sda_out  (sda_out),
      .sda_oe_n (sda_oe_n),
      .rd_addr  (rd_addr),
      .rd_data  (rd_data),
      .wr       (wr)
   );

   assign rate_sel = rate_cfg_r[RATE_SEL_LSB +: 3];
   assign debounce = rate_cfg_r[DEBOUNCE_LSB +: 3];
   assign exclude  = {tap_cfg_r[Z_EXCLUDE_BIT], tap_cfg_r[Y_EXCLUDE_BIT],
                      tap_cfg_r[X_EXCLUDE_BIT]};
   assign active   = mode_r[MODE_ACTIVE_BIT];
   assign entry    = active & ~active_d_r;

   // configuration writes; the host is trusted to be in standby here
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mode_r     <= MODE_RESET;
         rate_cfg_r <= RATE_RESET;
         tap_cfg_r  <= TAP_CFG_RESET;
      end else if (wr.wr_en) begin
         if (wr.addr == ADDR_MODE) begin
            mode_r <= wr.data & 8'hc1;
         end
         if (wr.addr == ADDR_RATE) begin
            rate_cfg_r <= wr.data & 8'he7;
         end
         if (wr.addr == ADDR_TAP_CFG) begin
            tap_cfg_r <= wr.data;
         end
      end
   end

   // read mux; unmapped addresses return zero
   always_comb begin
      unique case (rd_addr)
         ADDR_X_RESULT:   rd_data = axis_result.x;
         ADDR_Y_RESULT:   rd_data = axis_result.y;
         ADDR_Z_RESULT:   rd_data = axis_result.z;
         ADDR_TILT:       rd_data = {5'h00, orientation};
         ADDR_MODE:       rd_data = mode_r;
         ADDR_RATE:       rd_data = rate_cfg_r;
         ADDR_TAP_CFG:    rd_data = tap_cfg_r;
         ADDR_ENG_STATUS: rd_data = {3'h0, last_hit_r, active,
                                     freefall_enable};
         default:         rd_data = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // rate generation
   // ------------------------------------------------------------
   // fixed 200 sps tap tick, restarted at active entry
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         active_d_r <= 1'b0;
         tick_cnt_r <= '0;
         tap_tick   <= 1'b0;
      end else begin
         active_d_r <= active;
         tap_tick   <= 1'b0;
         if (!active || entry) begin
            tick_cnt_r <= '0;
         end else if (tick_cnt_r == TICK_W'(TAP_TICK_CYC - 1)) begin
            tick_cnt_r <= '0;
            tap_tick   <= 1'b1;
         end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
         end
      end
   end

   // slower output rates are divisions of the tap tick
   assign div_mask  = rate_mask(rate_sel);
   assign rate_tick = tap_tick & ((div_cnt_r & div_mask) == div_mask);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         div_cnt_r <= '0;
      end else if (entry) begin
         div_cnt_r <= '0;
      end else if (tap_tick) begin
         div_cnt_r <= div_cnt_r + 1'b1;
      end
   end

   // free-fall only runs at the two fastest codes
   assign freefall_enable = active & (rate_sel < RATE_100_SPS);

   // ------------------------------------------------------------
   // axis results
   // ------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         axis_result <= '0;
      end else if (rate_tick) begin
         axis_result <= axis_sample;
      end
   end

   // ------------------------------------------------------------
   // tilt debounce
   // ------------------------------------------------------------
   // match_r counts agreeing readings of the candidate, saturating at 7
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cand_r      <= 3'h0;
         match_r     <= 3'h0;
         orientation <= 3'h0;
      end else if (entry) begin
         match_r <= 3'h0;
      end else if (rate_tick) begin
         if (debounce == 3'h0) begin
            orientation <= orient_sample;
         end else if (match_r == 3'h0 || orient_sample != cand_r) begin
            cand_r  <= orient_sample;
            match_r <= 3'h1;
         end else begin
            if (match_r != 3'h7) begin
               match_r <= match_r + 3'h1;
            end
            if (match_r >= debounce) begin
               orientation <= cand_r;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // tap compare
   // ------------------------------------------------------------
   // code zero is clamped to one step, so 00000 and 00001 match
   assign thr_lsb = 8'(((tap_cfg_r[TAP_THR_LSB +: 5] == 5'h00) ? 5'h01
                        : tap_cfg_r[TAP_THR_LSB +: 5])
                       * TAP_STEP_LSB);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         prev_r     <= '0;
         prev_ok_r  <= 1'b0;
         tap_hit    <= 3'h0;
         last_hit_r <= 3'h0;
      end else begin
         tap_hit <= 3'h0;
         if (!active) begin
            prev_ok_r <= 1'b0;
         end else if (tap_tick) begin
            prev_r    <= axis_sample;
            prev_ok_r <= 1'b1;
            if (prev_ok_r) begin
               tap_hit <= ~exclude & {
                  abs_diff(axis_sample.z, prev_r.z) > {1'b0, thr_lsb},
                  abs_diff(axis_sample.y, prev_r.y) > {1'b0, thr_lsb},
                  abs_diff(axis_sample.x, prev_r.x) > {1'b0, thr_lsb}
               };
            end
         end
         if (tap_hit != 3'h0) begin
            last_hit_r <= tap_hit;
         end
      end
   end

endmodule

// ### testbench/artc_cfg_properties.sv
// port assertions for the motion configuration block
module artc_cfg_properties
   import artc_pkg::*;
#(
   parameter int TAP_TICK_CYC = TAP_PERIOD_CYC
)(
   input wire logic          clock,
   input wire logic          reset,
   input wire logic          sda_out,
   input wire artc_axes_type axis_sample,
   input wire artc_axes_type axis_result,
   input wire logic [2:0]    orientation,
   input wire logic          active,
   input wire logic          tap_tick,
   input wire logic          rate_tick,
   input wire logic [2:0]    tap_hit,
   input wire logic          freefall_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // ---------------------------------------------
   // helper: cycles since last tick, tick seen
   // ---------------------------------------------
   int   gap_r;
   logic seen_r;
   // seen clears in standby so the first tick is never timed
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         gap_r  <= 0;
         seen_r <= 1'b0;
      end else begin
         gap_r  <= tap_tick ? 0 : gap_r + 1;
         seen_r <= active & (seen_r | tap_tick);
      end
   end
   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   tick_pulse_a: assert property (tap_tick |=> !tap_tick)
      else $error("tap tick longer than one cycle");
   tick_period_a: assert property (
      tap_tick && seen_r |-> gap_r == TAP_TICK_CYC - 1)
      else $error("tap tick spacing wrong");
   tick_standby_a: assert property (!active |=> !tap_tick)
      else $error("tap tick while in standby");
   rate_on_tap_a: assert property (rate_tick |-> tap_tick)
      else $error("rate tick off the tap grid");
   result_load_a: assert property (
      rate_tick |=> axis_result == $past(axis_sample))
      else $error("axis result not loaded");
   result_hold_a: assert property (
      !rate_tick |=> $stable(axis_result))
      else $error("axis result moved between rate ticks");
   orient_hold_a: assert property (
      !rate_tick |=> $stable(orientation))
      else $error("orientation moved between rate ticks");
   first_tap_a: assert property (
      tap_tick && !seen_r |=> tap_hit == 3'h0)
      else $error("tap hit on first sample");
   hit_after_a: assert property (tap_hit != 3'h0 |-> $past(tap_tick))
      else $error("tap hit without tap tick");
   freefall_rate_a: assert property (
      freefall_enable && tap_tick |-> rate_tick)
      else $error("free fall enabled at slow rate");
   freefall_mode_a: assert property (freefall_enable |-> active)
      else $error("free fall enabled in standby");
   drain_only_a: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
endmodule

bind artc_motion_cfg artc_cfg_properties #(.TAP_TICK_CYC(TAP_TICK_CYC)) props (
   .clock(clock), .reset(reset), .sda_out(sda_out),
   .axis_sample(axis_sample), .axis_result(axis_result),
   .orientation(orientation), .active(active), .tap_tick(tap_tick),
   .rate_tick(rate_tick), .tap_hit(tap_hit),
   .freefall_enable(freefall_enable));

// ### testbench/artc_host_model.sv
// i2c host controller model driving scl and pulling sda
module artc_host_model
   import artc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary value
)(
   input  wire logic clock,
   input  wire logic sda,
   output      logic scl,
   output      logic sda_pull
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end
   // third of a bit: sda never moves in the cycle scl moves
   task automatic qtr;
      repeat (8) @(negedge clock);
   endtask
   task automatic bit_io(input logic b, output logic s);
      sda_pull = !b;
      qtr();
      scl = 1'b1;
      qtr();
      s   = sda;
      scl = 1'b0;
      qtr();
   endtask
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
   endtask
   // serves as start and repeated start
   task automatic start;
      sda_pull = 1'b0;
      qtr();
      scl = 1'b1;
      qtr();
      sda_pull = 1'b1;
      qtr();
      scl = 1'b0;
      qtr();
   endtask
   task automatic stop;
      sda_pull = 1'b1;
      qtr();
      scl = 1'b1;
      qtr();
      sda_pull = 1'b0;
      qtr();
   endtask
   // address, pointer, one data byte; ok when all three acked
   task automatic write_reg(input logic [7:0] r, input logic [7:0] d,
                            output logic ok);
      logic [7:0] q;
      logic [2:0] n;
      start();
      byte_io({DEV_ADDR, 1'b0}, q);
      bit_io(1'b1, n[0]);
      byte_io(r, q);
      bit_io(1'b1, n[1]);
      byte_io(d, q);
      bit_io(1'b1, n[2]);
      stop();
      ok = (n === 3'h0);
   endtask
   // pointer write, repeated start, one byte ended by nak
   task automatic read_reg(input logic [7:0] r, output logic [7:0] d,
                           output logic ok);
      logic [7:0] q;
      logic [3:0] n;
      start();
      byte_io({DEV_ADDR, 1'b0}, q);
      bit_io(1'b1, n[0]);
      byte_io(r, q);
      bit_io(1'b1, n[1]);
      start();
      byte_io({DEV_ADDR, 1'b1}, q);
      bit_io(1'b1, n[2]);
      byte_io(8'hff, d);
      bit_io(1'b1, n[3]);
      stop();
      ok = (n[2:0] === 3'h0);
   endtask
endmodule

// ### testbench/accel_rate_debounce_tap_cfg_test.sv
// self-checking bench for the motion configuration block
module accel_rate_debounce_tap_cfg_test;
   import artc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 48;
   logic          clock = 1'b0;
   logic          reset = 1'b1;
   logic          scl, sda_pull, sda_oe_n, active, tap_tick, rate_tick;
   logic          freefall_enable, ok;
   logic [2:0]    orient_sample = 3'h0;
   logic [2:0]    orientation, tap_hit;
   logic [7:0]    rd;
   artc_axes_type axis_sample = '0;
   artc_axes_type axis_result;
   int            n_fail = 0;
   int            compares = 0;
   int            cycles = 0;
   // open drain with pull-up: low when either side pulls
   wire logic sda = !(sda_pull | !sda_oe_n);
   artc_motion_cfg #(.TAP_TICK_CYC(TICK)) DUT (
      .clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda),
      .sda_out(), .sda_oe_n(sda_oe_n), .axis_sample(axis_sample),
      .orient_sample(orient_sample), .axis_result(axis_result),
      .orientation(orientation), .active(active), .tap_tick(tap_tick),
      .rate_tick(rate_tick), .tap_hit(tap_hit),
      .freefall_enable(freefall_enable));
   artc_host_model HOST (.clock(clock), .sda(sda), .scl(scl),
                         .sda_pull(sda_pull));
   always #2.5 clock = !clock;
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // config is written only from standby
   task automatic configure(input logic [7:0] rate, input logic [7:0] tap);
      HOST.write_reg(ADDR_MODE, 8'h00, ok);
      HOST.write_reg(ADDR_RATE, rate, ok);
      HOST.write_reg(ADDR_TAP_CFG, tap, ok);
      HOST.write_reg(ADDR_MODE, 8'h01, ok);
   endtask
   // hold orientation o for k rate samples
   task automatic rticks(input int k, input logic [2:0] o);
      orient_sample = o;
      repeat (k) begin
         do @(negedge clock); while (rate_tick !== 1'b1);
      end
      @(negedge clock);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_regs;
      HOST.read_reg(ADDR_TAP_CFG, rd, ok);
      check("tap cfg reset", TAP_CFG_RESET, rd);
      HOST.read_reg(ADDR_RATE, rd, ok);
      check("rate reset", RATE_RESET, rd);
      HOST.write_reg(ADDR_TAP_CFG, 8'ha5, ok);
      HOST.read_reg(ADDR_TAP_CFG, rd, ok);
      check("tap cfg rw", 8'ha5, rd);
      HOST.write_reg(ADDR_RATE, 8'hff, ok);
      HOST.read_reg(ADDR_RATE, rd, ok);
      check("rate reserved", 8'he7, rd);
      HOST.write_reg(8'h0a, 8'h55, ok);
      HOST.read_reg(8'h0a, rd, ok);
      check("unmapped", 8'h00, rd);
      check("ack", 8'h01, {7'h0, ok});
   endtask
   // every code: rate ticks per 64 tap ticks, free-fall level
   task automatic t_rates;
      int div, nr, t;
      for (int i = 0; i < 8; i++) begin
         configure(8'(i), 8'h00);
         div = (i < 2) ? 1 : 1 << (i - 1);
         nr  = 0;
         t   = 0;
         while (t < 64) begin
            @(negedge clock);
            t  += int'(tap_tick);
            nr += int'(rate_tick);
            axis_sample = axis_sample + 24'h010203;
         end
         check("rate ticks", 8'(64 / div), 8'(nr));
         check("freefall", {7'h0, i < 2}, {7'h0, freefall_enable});
         if (i == 0) begin
            HOST.write_reg(ADDR_MODE, 8'h00, ok);
            HOST.read_reg(ADDR_Z_RESULT, rd, ok);
            check("z result reg", axis_sample.z, rd);
         end
      end
   endtask
   task automatic t_debounce;
      configure(8'h60, 8'h00);
      rticks(3, 3'h5);
      check("tilt before 4", 8'h00, {5'h0, orientation});
      rticks(1, 3'h5);
      check("tilt at 4", 8'h05, {5'h0, orientation});
      rticks(3, 3'h2);
      rticks(1, 3'h6);
      rticks(3, 3'h2);
      check("tilt restart", 8'h05, {5'h0, orientation});
      rticks(1, 3'h2);
      check("tilt new", 8'h02, {5'h0, orientation});
      configure(8'h00, 8'h00);
      rticks(1, 3'h3);
      check("tilt no filter", 8'h03, {5'h0, orientation});
      configure(8'he0, 8'h00);
      rticks(7, 3'h1);
      check("tilt before 8", 8'h03, {5'h0, orientation});
      rticks(1, 3'h1);
      check("tilt at 8", 8'h01, {5'h0, orientation});
   endtask
   // one excluded axis each, thresholds 1, 17, 31 at the edge
   task automatic t_tap;
      logic [7:0]    cfg [3] = '{8'h40, 8'h31, 8'h9f};
      artc_axes_type s1 [3] = '{24'h010502, 24'heeee11, 24'h201f7f};
      logic [7:0]    hit [3] = '{8'h04, 8'h02, 8'h01};
      for (int i = 0; i < 3; i++) begin
         axis_sample = '0;
         configure(8'h00, cfg[i]);
         do @(negedge clock); while (tap_tick !== 1'b1);
         @(negedge clock);
         check("first tap", 8'h00, {5'h0, tap_hit});
         axis_sample = s1[i];
         do @(negedge clock); while (tap_tick !== 1'b1);
         @(negedge clock);
         check("tap hit", hit[i], {5'h0, tap_hit});
      end
   endtask
   // ---------------------------------------------
   // verdict and watchdog
   // ---------------------------------------------
   task automatic complete_run;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // limit sized for about 73k cycles of traffic
   always @(posedge clock) begin
      cycles++;
      if (cycles == 95000) begin
         n_fail++;
         complete_run();
      end
   end
   initial begin
      repeat (12) @(negedge clock);
      reset = 1'b0;
      repeat (4) @(negedge clock);
      t_regs();
      t_rates();
      t_debounce();
      t_tap();
      complete_run();
   end
endmodule
